// *** src/mac_arith.sv ***
// product and accumulate arithmetic of the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none

module mac_arith (
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire mac_pkg::mac_mode_e mode,
  input wire logic [31:0] acc,
  output mac_pkg::mac_out_s result
);

  logic [31:0] prod_u;
  logic [31:0] prod_s;
  logic [32:0] sum_u;
  logic [31:0] sum_s;

  always_comb begin
    prod_u = {16'h0000, op_a} * {16'h0000, op_b};
    // operands widened first so the low product word is formed at full width
    prod_s = $signed({{16{op_a[15]}}, op_a}) * $signed({{16{op_b[15]}}, op_b});
    sum_u = {1'b0, acc} + {1'b0, prod_u};
    // wraps silently, no overflow or underflow detection
    sum_s = acc + prod_s;
    result.res = prod_u;
    result.ext = 16'h0000;
    unique case (mode)
      mac_pkg::MAC_UMUL: begin
        result.res = prod_u;
        result.ext = 16'h0000;
      end
      mac_pkg::MAC_SMUL: begin
        result.res = prod_s;
        result.ext = {16{prod_s[31]}};
      end
      mac_pkg::MAC_UACC: begin
        result.res = sum_u[31:0];
        result.ext = {15'h0000, sum_u[32]};
      end
      mac_pkg::MAC_SACC: begin
        result.res = sum_s;
        result.ext = {16{sum_s[31]}};
      end
    endcase
  end

endmodule

`default_nettype wire

// *** src/mac_lane.sv ***
// byte lane merge for writes and lane select for reads
`timescale 1ns/10ps
`default_nettype none

module mac_lane (
  input wire logic [15:0] old_word,
  input wire logic [15:0] wdata,
  input wire logic byte_acc,
  input wire logic hi_lane,
  input wire logic clear_upper,
  output logic [15:0] merged,
  output logic [15:0] read_view
);

  always_comb begin
    if (!byte_acc) begin
      merged = wdata;
      read_view = old_word;
    end else if (clear_upper) begin
      // operand byte writes zero the upper byte; software sign-extends
      merged = {8'h00, wdata[7:0]};
      read_view = hi_lane ? {8'h00, old_word[15:8]} : {8'h00, old_word[7:0]};
    end else if (hi_lane) begin
      merged = {wdata[7:0], old_word[7:0]};
      read_view = {8'h00, old_word[15:8]};
    end else begin
      merged = {old_word[15:8], wdata[7:0]};
      read_view = {8'h00, old_word[7:0]};
    end
  end

endmodule

`default_nettype wire

// *** src/mac_map.svh ***
// register offsets, field positions and reset values of the multiply-accumulate unit
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define MAC_OFS_OP1_UMUL 16'h0130
`define MAC_OFS_OP1_SMUL 16'h0132
`define MAC_OFS_OP1_UACC 16'h0134
`define MAC_OFS_OP1_SACC 16'h0136
`define MAC_OFS_OP2 16'h0138
`define MAC_OFS_RES_LO 16'h013a
`define MAC_OFS_RES_HI 16'h013c
`define MAC_OFS_SUM_EXT 16'h013e

// ----------------------------------------------------------------
// decode fields
// ----------------------------------------------------------------
`define MAC_BLOCK_MSB 15
`define MAC_BLOCK_LSB 4
`define MAC_BLOCK_BASE 12'h013
`define MAC_MODE_MSB 2
`define MAC_MODE_LSB 1
`define MAC_LANE_BIT 0
`define MAC_OP1_SEL_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MAC_RST_WORD 16'h0000
`define MAC_RST_MODE 2'h0

`endif

// *** src/mac_pkg.sv ***
// types shared by the multiply-accumulate unit
package mac_pkg;

  typedef enum logic [1:0] {
    MAC_UMUL = 2'b00,
    MAC_SMUL = 2'b01,
    MAC_UACC = 2'b10,
    MAC_SACC = 2'b11
  } mac_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic byte_acc;
  } mac_req_s;

  typedef struct packed {
    logic [31:0] res;
    logic [15:0] ext;
  } mac_out_s;

endpackage

// *** src/mac_unit.sv ***
// memory-mapped multiply and multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
`include "mac_map.svh"


module mac_unit (
  input wire logic core_clk,
  input wire logic rst,
  input wire mac_pkg::mac_req_s bus_req,
  output logic [15:0] bus_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] op1_q;
  logic [15:0] op1_d;
  logic [15:0] op2_q;
  logic [15:0] op2_d;
  logic [15:0] res_lo_q;
  logic [15:0] res_lo_d;
  logic [15:0] res_hi_q;
  logic [15:0] res_hi_d;
  logic [15:0] sum_ext_q;
  logic [15:0] sum_ext_d;
  mac_pkg::mac_mode_e mode_q;
  mac_pkg::mac_mode_e mode_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [15:0] word_addr;
  logic sel_umul;
  logic sel_smul;
  logic sel_uacc;
  logic sel_sacc;
  logic sel_op1;
  logic sel_op2;
  logic sel_lo;
  logic sel_hi;
  logic sel_ext;
  logic hi_lane;

  always_comb begin
    word_addr = {bus_req.addr[15:1], 1'b0};
    hi_lane = bus_req.addr[`MAC_LANE_BIT] & bus_req.byte_acc;
    // four aliases of the one first-operand register
    sel_umul = word_addr == `MAC_OFS_OP1_UMUL;
    sel_smul = word_addr == `MAC_OFS_OP1_SMUL;
    sel_uacc = word_addr == `MAC_OFS_OP1_UACC;
    sel_sacc = word_addr == `MAC_OFS_OP1_SACC;
    sel_op1 = sel_umul || sel_smul || sel_uacc || sel_sacc;
    sel_op2 = word_addr == `MAC_OFS_OP2;
    sel_lo = word_addr == `MAC_OFS_RES_LO;
    sel_hi = word_addr == `MAC_OFS_RES_HI;
    sel_ext = word_addr == `MAC_OFS_SUM_EXT;
  end

  // ----------------------------------------------------------------
  // byte lanes, one per register word
  // ----------------------------------------------------------------
  logic [15:0] op1_wr;
  logic [15:0] op2_wr;
  logic [15:0] lo_wr;
  logic [15:0] hi_wr;
  logic [15:0] op1_rd;
  logic [15:0] op2_rd;
  logic [15:0] lo_rd;
  logic [15:0] hi_rd;
  logic [15:0] ext_rd;

  mac_lane u_lane_op1 (
    .old_word(op1_q),
    .wdata(bus_req.wdata),
    .byte_acc(bus_req.byte_acc),
    .hi_lane(hi_lane),
    .clear_upper(1'b1),
    .merged(op1_wr),
    .read_view(op1_rd)
  );

  mac_lane u_lane_op2 (
    .old_word(op2_q),
    .wdata(bus_req.wdata),
    .byte_acc(bus_req.byte_acc),
    .hi_lane(hi_lane),
    .clear_upper(1'b1),
    .merged(op2_wr),
    .read_view(op2_rd)
  );

  mac_lane u_lane_lo (
    .old_word(res_lo_q),
    .wdata(bus_req.wdata),
    .byte_acc(bus_req.byte_acc),
    .hi_lane(hi_lane),
    .clear_upper(1'b0),
    .merged(lo_wr),
    .read_view(lo_rd)
  );

  mac_lane u_lane_hi (
    .old_word(res_hi_q),
    .wdata(bus_req.wdata),
    .byte_acc(bus_req.byte_acc),
    .hi_lane(hi_lane),
    .clear_upper(1'b0),
    .merged(hi_wr),
    .read_view(hi_rd)
  );

  mac_lane u_lane_ext (
    .old_word(sum_ext_q),
    .wdata(16'h0000),
    .byte_acc(bus_req.byte_acc),
    .hi_lane(hi_lane),
    .clear_upper(1'b0),
    .merged(),
    .read_view(ext_rd)
  );

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  mac_pkg::mac_out_s arith;

  // the new second operand feeds the arithmetic directly, so the
  // result lands on the same edge as the write and is ready next cycle
  mac_arith u_arith (
    .op_a(op1_q),
    .op_b(op2_wr),
    .mode(mode_q),
    .acc({res_hi_q, res_lo_q}),
    .result(arith)
  );

  // ----------------------------------------------------------------
  // write and read strobes
  // ----------------------------------------------------------------
  logic wr_op1;
  logic wr_op2;
  logic wr_lo;
  logic wr_hi;
  logic rd_op1;
  logic rd_op2;
  logic rd_lo;
  logic rd_hi;
  logic rd_ext;

  always_comb begin
    wr_op1 = bus_req.wr && sel_op1;
    wr_op2 = bus_req.wr && sel_op2;
    // one address a cycle keeps a start and a restore apart; should they
    // ever meet, the start wins so a fresh result is never half overwritten
    wr_lo = bus_req.wr && sel_lo && !wr_op2;
    wr_hi = bus_req.wr && sel_hi && !wr_op2;
    // no write strobe exists for the sum extension: it is read-only
    rd_op1 = bus_req.rd && sel_op1;
    rd_op2 = bus_req.rd && sel_op2;
    rd_lo = bus_req.rd && sel_lo;
    rd_hi = bus_req.rd && sel_hi;
    rd_ext = bus_req.rd && sel_ext;
  end

  // ----------------------------------------------------------------
  // first operand group
  // ----------------------------------------------------------------
  always_comb begin
    op1_d = op1_q;
    if (wr_op1) begin
      op1_d = op1_wr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op1_q <= `MAC_RST_WORD;
    end else begin
      op1_q <= op1_d;
    end
  end

  // ----------------------------------------------------------------
  // mode group
  // ----------------------------------------------------------------
  // only the last first-operand write counts; a routine that loads its own
  // first operand in between silently changes the mode
  always_comb begin
    mode_d = mode_q;
    if (wr_op1) begin
      // write-only copy of the mode; nothing reads it back
      mode_d = mac_pkg::mac_mode_e'(bus_req.addr[`MAC_MODE_MSB:`MAC_MODE_LSB]);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= mac_pkg::mac_mode_e'(`MAC_RST_MODE);
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // second operand group
  // ----------------------------------------------------------------
  // the operand keeps its value after a start, so a repeated second-operand
  // write reruns the multiply with the same first operand and mode
  always_comb begin
    op2_d = op2_q;
    if (wr_op2) begin
      op2_d = op2_wr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op2_q <= `MAC_RST_WORD;
    end else begin
      op2_q <= op2_d;
    end
  end

  // ----------------------------------------------------------------
  // result group: low word, high word, sum extension
  // ----------------------------------------------------------------
  always_comb begin
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    sum_ext_d = sum_ext_q;
    if (wr_op2) begin
      // accumulate modes fold the old result in inside the arithmetic
      res_lo_d = arith.res[15:0];
      res_hi_d = arith.res[31:16];
      sum_ext_d = arith.ext;
    end
    // save and restore path for nested use
    if (wr_lo) begin
      res_lo_d = lo_wr;
    end
    if (wr_hi) begin
      res_hi_d = hi_wr;
    end
  end

  // no interrupt, flag or enable exists; the result is final in one edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_lo_q <= `MAC_RST_WORD;
      res_hi_q <= `MAC_RST_WORD;
      sum_ext_q <= `MAC_RST_WORD;
    end else begin
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
      sum_ext_q <= sum_ext_d;
    end
  end

  // ----------------------------------------------------------------
  // read group
  // ----------------------------------------------------------------
  // idle data is zero, so the unit can sit on an or-tree of read buses
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_op1) begin
      rdata_d = op1_rd;
    end else if (rd_op2) begin
      rdata_d = op2_rd;
    end else if (rd_lo) begin
      rdata_d = lo_rd;
    end else if (rd_hi) begin
      rdata_d = hi_rd;
    end else if (rd_ext) begin
      rdata_d = ext_rd;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `MAC_RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

endmodule

`default_nettype wire

// *** verification/mac_cpu_model.sv ***
// processor-side bus model for the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module mac_cpu_model (
  input wire logic core_clk,
  output var mac_pkg::mac_req_s bus_req,
  input wire logic [15:0] bus_rdata
);
  initial bus_req = '0;
  // one access a cycle; returns the data of the access before, so reads run back to back
  task automatic xfer(input logic w, input logic r, input logic bt, input logic [15:0] ad, input logic [15:0] wd,
      output logic [15:0] prev);
    @(negedge core_clk);
    prev = bus_rdata;
    bus_req = '{addr: ad, wdata: wd, wr: w, rd: r, byte_acc: bt};
  endtask
  // operand writes stay adjacent: nothing may slip in that reloads the first operand
  task automatic run_op(input logic [1:0] m, input logic bt, input logic [15:0] a, input logic [15:0] b,
      output logic [15:0] lo, output logic [15:0] hi, output logic [15:0] ext, output logic [15:0] op1);
    logic [15:0] d;
    xfer(1'b1, 1'b0, bt, {12'h013, 1'b0, m, bt}, a, d);
    xfer(1'b1, 1'b0, bt, 16'h0138, b, d);
    xfer(1'b0, 1'b1, 1'b0, 16'h013a, 16'h0000, d);
    xfer(1'b0, 1'b1, 1'b0, 16'h013c, 16'h0000, lo);
    xfer(1'b0, 1'b1, 1'b0, 16'h013e, 16'h0000, hi);
    xfer(1'b0, 1'b1, 1'b0, {12'h013, 1'b0, ~m, 1'b0}, 16'h0000, ext);
    xfer(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, op1);
  endtask
endmodule
`default_nettype wire

// *** verification/mac_unit_sva.sv ***
// port assertions of the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module mac_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire mac_pkg::mac_req_s bus_req,
  input wire logic [15:0] bus_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic [15:0] ad = bus_req.addr;
  wire logic wrw = bus_req.wr & ~bus_req.byte_acc;
  wire logic rdw = bus_req.rd & ~bus_req.byte_acc & ~bus_req.wr;
  wire logic op1 = ad[15:3] == 13'h0026;
  wire logic ext = ad == 16'h013e;
  idle_read_zero_a:
    assert property (!bus_req.rd |=> bus_rdata == 16'h0000) else $error("read data not idle");
  byte_upper_zero_a:
    assert property (bus_req.rd & bus_req.byte_acc |=> bus_rdata[15:8] == 8'h00) else $error("byte read upper");
  unmapped_zero_a:
    assert property (bus_req.rd & ad[15:4] != 12'h013 |=> bus_rdata == 16'h0000) else $error("unmapped read");
  op1_alias_a:
    assert property (wrw & op1 ##1 rdw & op1 |=> bus_rdata == $past(bus_req.wdata, 2)) else $error("op1 alias");
  op1_byte_clear_a:
    assert property (bus_req.wr & bus_req.byte_acc & op1 ##1 rdw & op1
      |=> bus_rdata == {8'h00, $past(bus_req.wdata[7:0], 2)}) else $error("op1 byte");
  ext_read_only_a:
    assert property (rdw & ext ##1 bus_req.wr & ext & !bus_req.rd ##1 rdw & ext
      |=> bus_rdata == $past(bus_rdata, 2)) else $error("ext written");
  ext_values_a:
    assert property (rdw & ext |=> bus_rdata inside {16'h0000, 16'h0001, 16'hffff}) else $error("ext value");
  result_halves_a:
    assert property (wrw & ad == 16'h013a ##1 wrw & ad == 16'h013c ##1 rdw & ad == 16'h013a
      |=> bus_rdata == $past(bus_req.wdata, 3)) else $error("result halves");
  zero_product_a:
    assert property (wrw & ad == 16'h0130 ##1 wrw & ad == 16'h0138 & bus_req.wdata == 16'h0000
      ##1 rdw & ad == 16'h013a |=> bus_rdata == 16'h0000) else $error("zero product");
  cover property (wrw & ad == 16'h0138);
  cover property (bus_req.rd & bus_req.byte_acc);
  cover property (rdw & ext ##1 bus_rdata == 16'hffff);
endmodule
bind mac_unit mac_chk u_chk (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata));
`default_nettype wire

// *** verification/multiply_accumulate_unit_tb_top.sv ***
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module multiply_accumulate_unit_tb_top;
  logic core_clk;
  logic rst;
  logic [15:0] bus_rdata, a, b, lo, hi, ext, op1, d;
  mac_pkg::mac_req_s bus_req;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] lfsr_q = 32'h8922;
  logic [31:0] acc;
  logic [47:0] e;
  logic [1:0] m;
  logic bt;
  mac_unit dut_u (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata));
  mac_cpu_model cpu_u (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    for (int k = 0; k < 32; k++) s = {s[30:0], ^(s & 32'h80200003)};
    return s;
  endfunction
  // sign-extended operands truncated to 32 bits give the two's complement product
  function automatic logic [47:0] model(input logic [1:0] md, input logic [15:0] x, input logic [15:0] y,
      input logic [31:0] c);
    logic [31:0] p;
    logic [32:0] s;
    p = md[0] ? {{16{x[15]}}, x} * {{16{y[15]}}, y} : {16'h0000, x} * {16'h0000, y};
    s = {1'b0, md[1] ? c : 32'h0} + {1'b0, p};
    return {md[0] ? {16{s[31]}} : {15'h0000, s[32]}, s[31:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    cpu_u.xfer(1'b0, 1'b1, 1'b0, 16'h013e, 16'h0000, d);
    cpu_u.xfer(1'b1, 1'b0, 1'b0, 16'h013e, 16'h5a5a, d);
    cpu_u.xfer(1'b0, 1'b1, 1'b0, 16'h013e, 16'h0000, d);
    cpu_u.xfer(1'b1, 1'b1, 1'b0, 16'h0140, 16'h1234, ext);
    cpu_u.xfer(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, d);
    chk(ext, 16'h0000);
    chk(d, 16'h0000);
    a = lfsr_q[15:0] ^ 16'hc3a5;
    cpu_u.xfer(1'b1, 1'b0, 1'b0, 16'h0136, a, d);
    cpu_u.xfer(1'b0, 1'b1, 1'b0, 16'h0132, 16'h0000, d);
    cpu_u.xfer(1'b1, 1'b0, 1'b1, 16'h0135, a, op1);
    cpu_u.xfer(1'b0, 1'b1, 1'b0, 16'h0130, 16'h0000, d);
    cpu_u.xfer(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, d);
    chk(op1, a);
    chk(d, {8'h00, a[7:0]});
    for (int i = 0; i < 40; i++) begin
      lfsr_q = nxt(lfsr_q);
      {a, b} = lfsr_q;
      lfsr_q = nxt(lfsr_q);
      acc = lfsr_q;
      m = i[1:0];
      bt = i[4];
      case (i)
        0: {m, a, b, acc} = {2'h3, 16'h7fff, 16'h7fff, 32'h7fffffff};
        1: {m, a, b, acc} = {2'h2, 16'hffff, 16'hffff, 32'hffffffff};
        2: {m, b} = {2'h0, 16'h0000};
        default: ;
      endcase
      cpu_u.xfer(1'b1, 1'b0, 1'b0, 16'h013a, acc[15:0], d);
      cpu_u.xfer(1'b1, 1'b0, 1'b0, 16'h013c, {~acc[31:24], acc[23:16]}, d);
      cpu_u.xfer(1'b0, 1'b1, 1'b0, 16'h013a, 16'h0000, d);
      cpu_u.xfer(1'b1, 1'b0, 1'b1, 16'h013d, {b[7:0], acc[31:24]}, d);
      chk(d, acc[15:0]);
      cpu_u.run_op(m, bt, a, b, lo, hi, ext, op1);
      if (bt) {a, b} = {8'h00, a[7:0], 8'h00, b[7:0]};
      e = model(m, a, b, acc);
      chk(lo, e[15:0]);
      chk(hi, e[31:16]);
      chk(ext, e[47:32]);
      chk(op1, a);
      cpu_u.xfer(1'b0, 1'b1, 1'b1, 16'h013d, 16'h0000, d);
      cpu_u.xfer(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, d);
      chk(d, {8'h00, e[31:24]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
